// ===== bench/scs_host_model.sv
// Purpose: Host model that frames commands on the serial link.
// Assumes: Mode 0, MSB first, 32 ns link clock, data-out pulled up.
// Notes:   The link clock stands still outside frames.
`timescale 1ns/1ps
module scs_host_model (
  output logic      spi_clk, // Link clock.
  output logic      cs_n,    // Select, low.
  output logic      mosi,    // Data to card.
  input  wire logic miso     // Resolved data-out.
);
  // Idle levels: deselected, clock low, data-in high.
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // One byte each way; data set while low, read just before the rise.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #16;
      rx[i] = miso;
      spi_clk = 1'b1;
      #16;
      spi_clk = 1'b0;
    end
  endtask : xbyte
  // Sends one command and gathers the answer and the byte after it.
  task automatic xfer(input logic [5:0] idx, input logic [7:0] crc,
                      input logic two,
                      output logic [7:0] r1, output logic [7:0] r2,
                      output logic [7:0] nx);
    logic [7:0] rx;
    int         n;
    cs_n = 1'b0;
    #8;
    xbyte({2'h1, idx}, rx);
    for (int i = 0; i < 4; i++) begin
      xbyte(8'h00, rx);
    end
    xbyte(crc, rx);
    r1 = 8'hff;
    n = 0;
    while (r1 == 8'hff && n < 12) begin
      xbyte(8'hff, r1);
      n++;
    end
    r2 = 8'hff;
    if (two) begin
      xbyte(8'hff, r2);
    end
    xbyte(8'hff, nx);
    for (int i = 0; i < 4; i++) begin
      xbyte(8'hff, rx);
    end
    #8;
    cs_n = 1'b1;
    #40;
  endtask : xfer
  // Clocks idle bytes while selected; the second carries a queued token.
  task automatic xread(output logic [7:0] rx);
    logic [7:0] d;
    cs_n = 1'b0;
    #8;
    xbyte(8'hff, d);
    xbyte(8'hff, rx);
    for (int i = 0; i < 4; i++) begin
      xbyte(8'hff, d);
    end
    #8;
    cs_n = 1'b1;
    #40;
  endtask : xread
endmodule : scs_host_model

// ===== bench/scs_status_top_tb.sv
// Purpose: Self-checking bench for the card status reporting block.
// Assumes: Core side judges every command one cycle after its strobe.
// Notes:   Events are pulsed on the core clock between frames.
`timescale 1ns/1ps
module scs_status_top_tb;
  import scs_pkg::*;
  logic             core_clk, nrst, spi_clk, cs_n, mosi, miso, miso_oe;
  logic             cmd_stb, crc_ok, cmd_done, ill, crc_en, init_done;
  logic             locked, busy, tok;
  logic [5:0]       cmd_index;
  logic [31:0]      cmd_arg;
  logic [12:0]      ev;
  logic [NFLAG-1:0] flags;
  logic [7:0]       r1, r2, nx;
  int               bad_count, n_compared, cyc;
  wire              miso_w = miso_oe ? miso : 1'b1;
  scs_status_top u_scs_status_top (
    .CORE_CLK(core_clk), .NRST(nrst), .SPI_CLK(spi_clk), .CS_N(cs_n),
    .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .CMD_STB(cmd_stb),
    .CMD_INDEX(cmd_index), .CMD_ARG(cmd_arg), .CMD_CRC_OK(crc_ok),
    .CMD_DONE(cmd_done), .CMD_ILLEGAL(ill), .CRC_CHECK_EN(crc_en),
    .INIT_DONE(init_done), .CARD_LOCKED(locked), .CARD_BUSY(busy),
    .TOKEN_REQ(tok), .EV_RANGE(ev[0]), .EV_MISALIGN(ev[1]),
    .EV_ERASE_SEQ(ev[2]), .EV_ERASE_PARAM(ev[3]), .EV_PARAM(ev[4]),
    .EV_WP_VIOL(ev[5]), .EV_ECC_FAIL(ev[6]), .EV_CC_FAULT(ev[7]),
    .EV_GENERAL(ev[8]), .EV_WP_SKIP(ev[9]), .EV_LOCK_FAIL(ev[10]),
    .EV_ERASE_RESET(ev[11]), .EV_CSD_OVERWRITE(ev[12]), .FLAGS(flags));
  scs_host_model u_scs_host_model (
    .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
  // Core clock of 20 ns.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Core side judges each command right after its strobe; hang guard.
  always @(posedge core_clk) begin
    cmd_done <= cmd_stb;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      close_out();
    end
  end
  // Compares two values and counts the outcome.
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // Idle bit before init, fill after the answer, floating when deselected.
  task automatic t_idle();
    chk(16'h0, miso_oe);
    u_scs_host_model.xfer(6'h00, 8'h95, 1'b0, r1, r2, nx);
    chk(16'h01, r1);
    chk(16'h1, crc_ok);
    chk(16'h00, cmd_index);
    chk(16'h0, cmd_arg[31:16] | cmd_arg[15:0]);
    chk(16'hff, nx);
    @(posedge core_clk);
    init_done <= 1'b1;
    $display("test idle done");
  endtask : t_idle
  // Every event is sticky, reported once by status request, then cleared.
  task automatic t_events();
    @(posedge core_clk);
    ev <= '1;
    locked <= 1'b1;
    @(posedge core_clk);
    ev <= '0;
    @(posedge core_clk);
    chk(16'h7f3f, flags);
    u_scs_host_model.xfer(STATUS_CMD_IDX, 8'h01, 1'b1, r1, r2, nx);
    chk(16'h72, r1);
    chk(16'hff, r2);
    chk(16'h0, flags);
    u_scs_host_model.xfer(STATUS_CMD_IDX, 8'h01, 1'b1, r1, r2, nx);
    chk(16'h00, r1);
    chk(16'h01, r2);
    $display("test events done");
  endtask : t_events
  // Failure token clears its bits at once, then carries them at the second idle byte.
  task automatic t_token();
    @(posedge core_clk);
    ev <= 13'h0061;
    @(posedge core_clk);
    ev  <= '0;
    tok <= 1'b1;
    @(posedge core_clk);
    tok <= 1'b0;
    @(posedge core_clk);
    chk(16'h0020, flags);
    u_scs_host_model.xread(r1);
    chk(16'h1c, r1);
    $display("test token done");
  endtask : t_token
  // Bad checksum and illegal command in the short answer, then cleared.
  task automatic t_crc();
    @(posedge core_clk);
    crc_en <= 1'b1;
    ill <= 1'b1;
    u_scs_host_model.xfer(6'h11, 8'h01, 1'b0, r1, r2, nx);
    chk(16'h0c, r1);
    chk(16'h0, crc_ok);
    chk(16'h11, cmd_index);
    @(posedge core_clk);
    crc_en <= 1'b0;
    ill <= 1'b0;
    u_scs_host_model.xfer(6'h11, 8'h01, 1'b0, r1, r2, nx);
    chk(16'h00, r1);
    $display("test crc done");
  endtask : t_crc
  // Busy card sends zero bytes after its answer.
  task automatic t_busy();
    @(posedge core_clk);
    busy <= 1'b1;
    u_scs_host_model.xfer(6'h11, 8'h01, 1'b0, r1, r2, nx);
    chk(16'h00, r1);
    chk(16'h00, nx);
    $display("test busy done");
  endtask : t_busy
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // Reset for five cycles, then the scenarios in turn.
  initial begin
    {cmd_done, ill, crc_en, init_done, locked, busy, tok} = '0;
    nrst = 1'b1;
    ev = '0;
    {bad_count, n_compared, cyc} = '0;
    // A real falling edge resets the link side, whose clock stands still.
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_idle();
    t_events();
    t_token();
    t_crc();
    t_busy();
    close_out();
  end
endmodule : scs_status_top_tb

// ===== pkg/scs_pkg.sv
// Purpose: Shared constants and types for the card status reporting block.
// Assumes: Serial link is byte aligned to chip select; MSB first.
// Notes:   Flag indices address the sticky error vector inside the core.
package scs_pkg;

  // Sticky flag indices.
  localparam int NFLAG         = 15;
  localparam int F_RANGE       = 0;
  localparam int F_MISALIGN    = 1;
  localparam int F_ERASE_SEQ   = 2;
  localparam int F_ERASE_PARAM = 3;
  localparam int F_PARAM       = 4;
  localparam int F_WP_VIOL     = 5;
  localparam int F_CRC         = 6;
  localparam int F_ILLEGAL     = 7;
  localparam int F_ECC         = 8;
  localparam int F_CC          = 9;
  localparam int F_GENERAL     = 10;
  localparam int F_WP_SKIP     = 11;
  localparam int F_LOCK_FAIL   = 12;
  localparam int F_ERASE_RESET = 13;
  localparam int F_CSD_OVR     = 14;

  // Bit positions in the short response (bit 7 always zero).
  localparam int SR_IDLE      = 0;
  localparam int SR_ERASE_RST = 1;
  localparam int SR_ILLEGAL   = 2;
  localparam int SR_CRC       = 3;
  localparam int SR_ERASE_SEQ = 4;
  localparam int SR_ADDR      = 5;
  localparam int SR_PARAM     = 6;

  // Bit positions in the second status byte and in the failure token.
  localparam int ST_LOCKED   = 0;
  localparam int ST_SKIP     = 1;
  localparam int ST_GENERAL  = 2;
  localparam int ST_CC       = 3;
  localparam int ST_ECC      = 4;
  localparam int ST_WP_VIOL  = 5;
  localparam int ST_ERASE_PR = 6;
  localparam int ST_RANGE    = 7;
  localparam int TK_GENERAL  = 0;
  localparam int TK_CC       = 1;
  localparam int TK_ECC      = 2;
  localparam int TK_RANGE    = 3;
  localparam int TK_LOCKED   = 4;

  // Read-clear masks per answer format.
  localparam logic [NFLAG-1:0] MASK_SHORT =
    (15'h1 << F_ERASE_RESET) | (15'h1 << F_ILLEGAL) | (15'h1 << F_CRC) |
    (15'h1 << F_ERASE_SEQ) | (15'h1 << F_MISALIGN) | (15'h1 << F_PARAM);
  localparam logic [NFLAG-1:0] MASK_STATUS = 15'h7fff;
  localparam logic [NFLAG-1:0] MASK_TOKEN =
    (15'h1 << F_GENERAL) | (15'h1 << F_CC) | (15'h1 << F_ECC) |
    (15'h1 << F_RANGE) | (15'h1 << F_CSD_OVR);

  // Link constants; delays are counted in byte periods.
  localparam logic [7:0] FILL_BYTE      = 8'hff;
  localparam logic [7:0] BUSY_BYTE      = 8'h00;
  localparam logic [1:0] START_BITS     = 2'h1;
  localparam logic [5:0] STATUS_CMD_IDX = 6'h0d;
  localparam logic [3:0] RSP_DELAY_MIN  = 4'h1;
  localparam logic [3:0] RSP_DELAY_MAX  = 4'h8;
  localparam logic [6:0] CRC7_POLY      = 7'h09;
  localparam logic [2:0] CMD_LAST_BYTE  = 3'h5;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_CMD  = 3'b001,
    L_WAIT = 3'b011,
    L_RSP  = 3'b010,
    L_BUSY = 3'b110
  } scs_lstate_t;

  typedef enum logic {
    C_IDLE = 1'b0,
    C_EXEC = 1'b1
  } scs_cstate_t;

endpackage : scs_pkg

// ===== rtl/scs_status_top.sv
// Purpose: Status and error reporting of a flash card on its serial link.
// Assumes: Link mode 0, bytes aligned to chip select, MSB first.
// Notes:   Link side runs on SPI_CLK; sticky flags live on CORE_CLK.
`timescale 1ns/1ps
module scs_status_top
  import scs_pkg::*;
(
  input  wire logic                    CORE_CLK,         // Core clock.
  input  wire logic                    NRST,             // Reset, low.
  input  wire logic                    SPI_CLK,          // Link clock.
  input  wire logic                    CS_N,             // Select, low.
  input  wire logic                    MOSI,             // Data in.
  output logic                         MISO,             // Data out.
  output logic                         MISO_OE,          // Drive enable.
  output logic                         CMD_STB,          // New command.
  output logic [5:0]                   CMD_INDEX,        // Command index.
  output logic [31:0]                  CMD_ARG,          // Argument.
  output logic                         CMD_CRC_OK,       // Checksum good.
  input  wire logic                    CMD_DONE,         // Command judged.
  input  wire logic                    CMD_ILLEGAL,      // Not allowed now.
  input  wire logic                    CRC_CHECK_EN,     // Check checksum.
  input  wire logic                    INIT_DONE,        // Init finished.
  input  wire logic                    CARD_LOCKED,      // Password lock.
  input  wire logic                    CARD_BUSY,        // Busy after op.
  input  wire logic                    TOKEN_REQ,        // Send fail token.
  input  wire logic                    EV_RANGE,         // Arg out of range.
  input  wire logic                    EV_MISALIGN,      // Misaligned addr.
  input  wire logic                    EV_ERASE_SEQ,     // Erase order.
  input  wire logic                    EV_ERASE_PARAM,   // Erase params.
  input  wire logic                    EV_PARAM,         // Bad parameter.
  input  wire logic                    EV_WP_VIOL,       // Program to WP.
  input  wire logic                    EV_ECC_FAIL,      // ECC failed.
  input  wire logic                    EV_CC_FAULT,      // Controller fault.
  input  wire logic                    EV_GENERAL,       // General error.
  input  wire logic                    EV_WP_SKIP,       // Erase skipped WP.
  input  wire logic                    EV_LOCK_FAIL,     // Lock op failed.
  input  wire logic                    EV_ERASE_RESET,   // Erase abandoned.
  input  wire logic                    EV_CSD_OVERWRITE, // Config overwrite.
  output logic [scs_pkg::NFLAG-1:0]    FLAGS             // Sticky flags.
);

  // Answer byte builders.
  function automatic logic [7:0] short_byte(input logic [NFLAG-1:0] f,
                                            input logic idle);
    logic [7:0] b;
    b               = 8'h00;
    b[SR_IDLE]      = idle;
    b[SR_ERASE_RST] = f[F_ERASE_RESET];
    b[SR_ILLEGAL]   = f[F_ILLEGAL];
    b[SR_CRC]       = f[F_CRC];
    b[SR_ERASE_SEQ] = f[F_ERASE_SEQ];
    b[SR_ADDR]      = f[F_MISALIGN];
    b[SR_PARAM]     = f[F_PARAM];
    return b;
  endfunction : short_byte

  function automatic logic [7:0] status_byte(input logic [NFLAG-1:0] f,
                                             input logic lock);
    logic [7:0] b;
    b              = 8'h00;
    b[ST_LOCKED]   = lock;
    b[ST_SKIP]     = f[F_WP_SKIP] | f[F_LOCK_FAIL];
    b[ST_GENERAL]  = f[F_GENERAL];
    b[ST_CC]       = f[F_CC];
    b[ST_ECC]      = f[F_ECC];
    b[ST_WP_VIOL]  = f[F_WP_VIOL];
    b[ST_ERASE_PR] = f[F_ERASE_PARAM];
    b[ST_RANGE]    = f[F_RANGE] | f[F_CSD_OVR];
    return b;
  endfunction : status_byte

  function automatic logic [7:0] token_byte(input logic [NFLAG-1:0] f,
                                            input logic lock);
    logic [7:0] b;
    b             = 8'h00;
    b[TK_GENERAL] = f[F_GENERAL];
    b[TK_CC]      = f[F_CC];
    b[TK_ECC]     = f[F_ECC];
    b[TK_RANGE]   = f[F_RANGE] | f[F_CSD_OVR];
    b[TK_LOCKED]  = lock;
    return b;
  endfunction : token_byte

  // Command checksum over the first five bytes.
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction : crc7

  // Core domain state.
  scs_cstate_t      cst_q, cst_d;
  logic [NFLAG-1:0] flag_q, flag_d, ev_ext, ev_v, seen_v, clr_v;
  logic [7:0]       rsp_hi_q, rsp_hi_d, rsp_lo_q, rsp_lo_d, tok_q, tok_d;
  logic             two_q, two_d, ack_q, ack_d, tokt_q, tokt_d;
  logic             req_s1_q, req_s2_q, req_seen_q, req_seen_d;
  logic             stb_q, stb_d, ccrc_q, ccrc_d;
  logic [5:0]       idx_q, idx_d;
  logic [31:0]      arg_q, arg_d;
  logic             take, done, is_status;

  // Link domain state.
  scs_lstate_t lst_q, lst_d, eff_st;
  logic [47:0] cmd_q, cmd_d;
  logic [6:0]  rx_q, rx_d;
  logic [7:0]  rx_byte, tx_q, tx_d, nxt;
  logic [2:0]  bit_q, bit_d, eff_bit, cnt_q, cnt_d;
  logic [3:0]  dly_q, dly_d;
  logic        miso_q, miso_d, sec_q, sec_d, reqt_q, reqt_d, lcrc_q, lcrc_d;
  logic        ack_s1_q, ack_s2_q, ack_seen_q, ack_seen_d;
  logic        tok_s1_q, tok_s2_q, tok_seen_q, tok_seen_d;
  logic        busy_s1_q, busy_s2_q, sel_q, oe_q, bound;

  // Core next state: sticky flags, command hand-off and answer snapshots.
  always_comb begin
    ev_ext                = '0;
    ev_ext[F_RANGE]       = EV_RANGE;
    ev_ext[F_MISALIGN]    = EV_MISALIGN;
    ev_ext[F_ERASE_SEQ]   = EV_ERASE_SEQ;
    ev_ext[F_ERASE_PARAM] = EV_ERASE_PARAM;
    ev_ext[F_PARAM]       = EV_PARAM;
    ev_ext[F_WP_VIOL]     = EV_WP_VIOL;
    ev_ext[F_ECC]         = EV_ECC_FAIL;
    ev_ext[F_CC]          = EV_CC_FAULT;
    ev_ext[F_GENERAL]     = EV_GENERAL;
    ev_ext[F_WP_SKIP]     = EV_WP_SKIP;
    ev_ext[F_LOCK_FAIL]   = EV_LOCK_FAIL;
    ev_ext[F_ERASE_RESET] = EV_ERASE_RESET;
    ev_ext[F_CSD_OVR]     = EV_CSD_OVERWRITE;
    is_status  = (idx_q == STATUS_CMD_IDX);
    take       = (cst_q == C_IDLE) && (req_s2_q != req_seen_q);
    done       = (cst_q == C_EXEC) && CMD_DONE;
    ev_v       = ev_ext;
    ev_v[F_CRC]     = done && CRC_CHECK_EN && !ccrc_q;
    ev_v[F_ILLEGAL] = done && CMD_ILLEGAL;
    seen_v     = flag_q | ev_v;
    clr_v      = '0;
    cst_d      = cst_q;
    req_seen_d = req_seen_q;
    stb_d      = 1'b0;
    idx_d      = idx_q;
    arg_d      = arg_q;
    ccrc_d     = ccrc_q;
    rsp_hi_d   = rsp_hi_q;
    rsp_lo_d   = rsp_lo_q;
    two_d      = two_q;
    ack_d      = ack_q;
    tok_d      = tok_q;
    tokt_d     = tokt_q;
    // Command words are stable in the link while its toggle is pending.
    if (take) begin
      req_seen_d = req_s2_q;
      idx_d      = cmd_q[45:40];
      arg_d      = cmd_q[39:8];
      ccrc_d     = lcrc_q;
      stb_d      = 1'b1;
      cst_d      = C_EXEC;
    end
    // Snapshot includes this cycle's events, so a set is never lost.
    if (done) begin
      rsp_hi_d = short_byte(seen_v, !INIT_DONE);
      ack_d    = ~ack_q;
      cst_d    = C_IDLE;
      if (is_status) begin
        rsp_lo_d = status_byte(seen_v, CARD_LOCKED);
        two_d    = 1'b1;
        clr_v    = MASK_STATUS;
      end else begin
        two_d    = 1'b0;
        clr_v    = MASK_SHORT;
      end
    end
    if (TOKEN_REQ) begin
      tok_d  = token_byte(seen_v, CARD_LOCKED);
      tokt_d = ~tokt_q;
      clr_v  = clr_v | MASK_TOKEN;
    end
    flag_d = seen_v & ~clr_v;
  end

  // Core registers and link-to-core toggle synchroniser.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cst_q      <= C_IDLE;
      flag_q     <= '0;
      rsp_hi_q   <= 8'h00;
      rsp_lo_q   <= 8'h00;
      tok_q      <= 8'h00;
      two_q      <= 1'b0;
      ack_q      <= 1'b0;
      tokt_q     <= 1'b0;
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_seen_q <= 1'b0;
      stb_q      <= 1'b0;
      idx_q      <= 6'h00;
      arg_q      <= 32'h0000_0000;
      ccrc_q     <= 1'b0;
    end else begin
      cst_q      <= cst_d;
      flag_q     <= flag_d;
      rsp_hi_q   <= rsp_hi_d;
      rsp_lo_q   <= rsp_lo_d;
      tok_q      <= tok_d;
      two_q      <= two_d;
      ack_q      <= ack_d;
      tokt_q     <= tokt_d;
      req_s1_q   <= reqt_q;
      req_s2_q   <= req_s1_q;
      req_seen_q <= req_seen_d;
      stb_q      <= stb_d;
      idx_q      <= idx_d;
      arg_q      <= arg_d;
      ccrc_q     <= ccrc_d;
    end
  end

  // Selection flops; deselect or reset floats data-out at once.
  always_ff @(posedge SPI_CLK or posedge CS_N or negedge NRST) begin
    if (CS_N || !NRST) begin
      sel_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      sel_q <= 1'b1;
      oe_q  <= 1'b1;
    end
  end

  // Link next state: framing, delay, answer, busy and token bytes.
  always_comb begin
    eff_bit    = sel_q ? bit_q : 3'h0;
    eff_st     = sel_q ? lst_q : L_IDLE;
    bound      = (eff_bit == 3'h7);
    rx_byte    = {rx_q, MOSI};
    rx_d       = rx_byte[6:0];
    bit_d      = eff_bit + 3'h1;
    lst_d      = eff_st;
    cmd_d      = cmd_q;
    cnt_d      = cnt_q;
    dly_d      = dly_q;
    sec_d      = sec_q;
    reqt_d     = reqt_q;
    lcrc_d     = lcrc_q;
    ack_seen_d = ack_seen_q;
    tok_seen_d = tok_seen_q;
    nxt        = FILL_BYTE;
    if (bound) begin
      unique case (eff_st)
        L_IDLE: begin
          ack_seen_d = ack_s2_q;
          if (rx_byte[7:6] == START_BITS) begin
            cmd_d = {cmd_q[39:0], rx_byte};
            cnt_d = 3'h1;
            lst_d = L_CMD;
          end else if (tok_s2_q != tok_seen_q) begin
            nxt        = tok_q;
            tok_seen_d = tok_s2_q;
          end
        end
        L_CMD: begin
          cmd_d = {cmd_q[39:0], rx_byte};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == CMD_LAST_BYTE) begin
            lcrc_d = (crc7(cmd_d[47:8]) == cmd_d[7:1]);
            reqt_d = ~reqt_q;
            dly_d  = RSP_DELAY_MIN;
            lst_d  = L_WAIT;
          end
        end
        L_WAIT: begin
          if (ack_s2_q != ack_seen_q && dly_q >= RSP_DELAY_MIN) begin
            nxt        = rsp_hi_q;
            sec_d      = two_q;
            ack_seen_d = ack_s2_q;
            lst_d      = L_RSP;
          end else if (dly_q != RSP_DELAY_MAX) begin
            dly_d = dly_q + 4'h1;
          end
        end
        L_RSP: begin
          if (sec_q) begin
            nxt   = rsp_lo_q;
            sec_d = 1'b0;
          end else if (busy_s2_q) begin
            nxt   = BUSY_BYTE;
            lst_d = L_BUSY;
          end else begin
            lst_d = L_IDLE;
          end
        end
        L_BUSY: begin
          if (busy_s2_q) begin
            nxt = BUSY_BYTE;
          end else begin
            lst_d = L_IDLE;
          end
        end
        default: begin
          lst_d = L_IDLE;
        end
      endcase
    end
    // Data-out changes after each rising edge for the host's next sample.
    if (!sel_q) begin
      tx_d   = FILL_BYTE;
      miso_d = 1'b1;
    end else if (bound) begin
      tx_d   = {nxt[6:0], 1'b1};
      miso_d = nxt[7];
    end else begin
      tx_d   = {tx_q[6:0], 1'b1};
      miso_d = tx_q[7];
    end
  end

  // Link registers and core-to-link synchronisers.
  always_ff @(posedge SPI_CLK or negedge NRST) begin
    if (!NRST) begin
      lst_q      <= L_IDLE;
      cmd_q      <= 48'h0;
      rx_q       <= 7'h00;
      bit_q      <= 3'h0;
      cnt_q      <= 3'h0;
      dly_q      <= 4'h0;
      tx_q       <= 8'hff;
      miso_q     <= 1'b1;
      sec_q      <= 1'b0;
      reqt_q     <= 1'b0;
      lcrc_q     <= 1'b0;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      ack_seen_q <= 1'b0;
      tok_s1_q   <= 1'b0;
      tok_s2_q   <= 1'b0;
      tok_seen_q <= 1'b0;
      busy_s1_q  <= 1'b0;
      busy_s2_q  <= 1'b0;
    end else begin
      lst_q      <= lst_d;
      cmd_q      <= cmd_d;
      rx_q       <= rx_d;
      bit_q      <= bit_d;
      cnt_q      <= cnt_d;
      dly_q      <= dly_d;
      tx_q       <= tx_d;
      miso_q     <= miso_d;
      sec_q      <= sec_d;
      reqt_q     <= reqt_d;
      lcrc_q     <= lcrc_d;
      ack_s1_q   <= ack_q;
      ack_s2_q   <= ack_s1_q;
      ack_seen_q <= ack_seen_d;
      tok_s1_q   <= tokt_q;
      tok_s2_q   <= tok_s1_q;
      tok_seen_q <= tok_seen_d;
      busy_s1_q  <= CARD_BUSY;
      busy_s2_q  <= busy_s1_q;
    end
  end

  // Outputs straight from flops.
  assign MISO       = miso_q;
  assign MISO_OE    = oe_q;
  assign CMD_STB    = stb_q;
  assign CMD_INDEX  = idx_q;
  assign CMD_ARG    = arg_q;
  assign CMD_CRC_OK = ccrc_q;
  assign FLAGS      = flag_q;

  // Answer snapshot sequences used by the checks below.
  sequence s_status_done;
    done && is_status && (ev_ext == '0) && !TOKEN_REQ;
  endsequence
  sequence s_short_done;
    done && !is_status && (ev_ext == '0) && !TOKEN_REQ;
  endsequence

  a_short_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_short_done |=> ((flag_q & MASK_SHORT) == '0) && (ack_q != $past(ack_q)))
    else $error("short answer did not clear its flags");
  a_status_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_status_done |=> (flag_q == '0) && two_q)
    else $error("status answer did not clear all flags");
  a_token_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    TOKEN_REQ && (ev_ext == '0) |=> ((flag_q & MASK_TOKEN) == '0))
    else $error("failure token did not clear its flags");
  a_event_kept: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    EV_WP_VIOL && !done
      |=> flag_q[F_WP_VIOL] ##1 (flag_q[F_WP_VIOL] || $past(done)))
    else $error("protection violation flag lost");
  a_crc_report: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    done && !is_status && (ev_ext == '0) && !TOKEN_REQ && CRC_CHECK_EN &&
      !ccrc_q |=> rsp_hi_q[SR_CRC] && !flag_q[F_CRC])
    else $error("checksum fault not reported and cleared");
  a_lock_follows: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_status_done |=> rsp_lo_q[ST_LOCKED] == $past(CARD_LOCKED))
    else $error("locked indicator does not follow state");
  a_idle_follows: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    done |=> (rsp_hi_q[SR_IDLE] == !$past(INIT_DONE)) && !rsp_hi_q[7])
    else $error("idle indicator or top bit wrong");
  a_fill_wait: assert property (@(posedge SPI_CLK) disable iff (!NRST)
    sel_q && lst_q == L_WAIT && lst_d == L_WAIT |=> miso_q)
    else $error("data-out not high during response delay");
  a_rsp_delay: assert property (@(posedge SPI_CLK) disable iff (!NRST)
    sel_q && lst_q == L_WAIT && lst_d == L_RSP |-> dly_q >= RSP_DELAY_MIN)
    else $error("answer sent before the response delay");
  a_busy_zero: assert property (@(posedge SPI_CLK) disable iff (!NRST)
    sel_q && lst_q == L_BUSY && lst_d == L_BUSY |=> !miso_q)
    else $error("busy byte not zero");

endmodule : scs_status_top
